// [hdl/ccd_top.sv]
// Cache configuration, debug readout and data cache command stall control
//
// Functional notes
// - Config bit 14 gates the user data cache exception.
// - Config bit 15 makes load data visible on the on-chip memory port.
// - Bit 20 enables cachable prefetch, bit 21 non-cachable prefetch.
// - Bit 22 picks eight-word, else four-word, non-cachable instruction requests.
// - Bit 23 turns instruction misses into non-cachable fetches without allocation.
// - Bit 27 selects tag or data, bit 31 selects way B; no sequence needed.
// - Instruction debug read indexes by address 18:26 into a 32-bit debug register.
// - Instruction tag readout: tag 0:21, valid 27, LRU 31.
// - Data word readout picks word by address 27:29 from selected way.
// - Data debug read returns directly; misaligned word read raises alignment fault.
// - Data tag readout: tag 0:19, dirty 26, valid 27, LRU 31.
// - Hits complete one load or store every cycle without stall.
// - Misses fill a buffer while accepting commands; target word forwarded next cycle.
// - Buffer write-back takes 3 cycles, 4 if dirty; new commands stall meanwhile.
// - Two loads may be pending; stall on dependent use or early later command.
// - With fill buffer busy and needed again, one more command then stall.
// - Up to three outstanding stores; further commands stall.
// - Up to two flushes pending before stalling.
// - Other cache operations wait for all prior ones and block later ones.
`timescale 1ns/1ps
`include "ccd_defs.svh"
module ccd_top #(
  parameter int SETS = `CCD_SETS
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // Configuration register move
  input wire logic CFG_WR_I,
  input wire logic [31:0] CFG_WDATA_I,
  output logic [31:0] CFG_RDATA_O,
  // Configuration decodes to the rest of the core
  output logic USER_EXC_EN_O,
  output logic LOAD_DEBUG_VISIBLE_O,
  output logic PREFETCH_CACHABLE_O,
  output logic PREFETCH_NONCACHABLE_O,
  output logic NC_REQ_EIGHT_WORDS_O,
  output logic FETCH_WITHOUT_ALLOCATE_O,
  // Cache array contents for debug readout (A way then B way)
  input wire logic [21:0] ITAG_A_I,
  input wire logic [21:0] ITAG_B_I,
  input wire logic [1:0] IVALID_I,
  input wire logic ILRU_B_I,
  input wire logic [19:0] DTAG_A_I,
  input wire logic [19:0] DTAG_B_I,
  input wire logic [1:0] DVALID_I,
  input wire logic [1:0] DDIRTY_I,
  input wire logic DLRU_B_I,
  // Array word write port used by line refills
  input wire logic ARR_WE_I,
  input wire logic ARR_SIDE_I,
  input wire logic ARR_WAY_I,
  input wire logic [8:0] ARR_SET_I,
  input wire logic [2:0] ARR_WORD_I,
  input wire logic [31:0] ARR_WDATA_I,
  // Pipeline command port
  input wire logic CMD_VALID_I,
  input wire logic [2:0] CMD_KIND_I,
  input wire logic CMD_HIT_I,
  input wire logic CMD_DIRTY_VICTIM_I,
  input wire logic [31:0] CMD_EA_I,
  input wire logic USES_LOAD_DATA_I,
  output logic CMD_STALL_O,
  output logic CMD_ACCEPT_O,
  // Debug results
  output logic [31:0] ICACHE_DEBUG_DATA_O,
  output logic DDEBUG_VALID_O,
  output logic [31:0] DDEBUG_DATA_O,
  output logic ALIGN_EXC_O,
  // Load forwarding
  output logic LOAD_FWD_VALID_O,
  output logic [31:0] LOAD_FWD_DATA_O,
  // Bus controller side
  input wire logic FILL_WORD_VALID_I,
  input wire logic FILL_TARGET_I,
  input wire logic [31:0] FILL_WORD_I,
  input wire logic FILL_LAST_I,
  input wire logic LOAD_DONE_I,
  input wire logic STORE_DONE_I,
  input wire logic FLUSH_DONE_I,
  input wire logic OTHER_DONE_I
);
  localparam int AW = $clog2(SETS) + 3;

  logic rst_s1, rst_n;
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Configuration register; only documented upper fields are writable
  logic [31:0] cache_config_zero;
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cache_config_zero <= `CCD_CFG_RESET;
    end
    else if (CFG_WR_I)
    begin
      cache_config_zero <= CFG_WDATA_I & `CCD_CFG_WMASK;
    end
  end
  // Bit numbers count from the most significant end
  function automatic logic cfg_bit(input logic [31:0] r, input int n);
    cfg_bit = r[31-n];
  endfunction : cfg_bit

  wire info_select = cfg_bit(cache_config_zero, `CCD_CFG_INFO);
  wire way_select = cfg_bit(cache_config_zero, `CCD_CFG_WAY);
  assign CFG_RDATA_O = cache_config_zero;
  assign USER_EXC_EN_O = cfg_bit(cache_config_zero, `CCD_CFG_UXE);
  assign LOAD_DEBUG_VISIBLE_O = cfg_bit(cache_config_zero, `CCD_CFG_LDV);
  assign PREFETCH_CACHABLE_O = cfg_bit(cache_config_zero, `CCD_CFG_PFC);
  assign PREFETCH_NONCACHABLE_O = cfg_bit(cache_config_zero, `CCD_CFG_PFN);
  assign NC_REQ_EIGHT_WORDS_O = cfg_bit(cache_config_zero, `CCD_CFG_NRS);
  assign FETCH_WITHOUT_ALLOCATE_O = cfg_bit(cache_config_zero, `CCD_CFG_FWA);

  // Command decode; address bits counted from the least significant end
  ccd_pkg::ccd_cmd_t kind;
  assign kind = ccd_pkg::ccd_cmd_t'(CMD_KIND_I);
  wire [8:0] ea_set = CMD_EA_I[13:5];
  wire [2:0] ea_word = CMD_EA_I[4:2];
  wire ea_misalign = |CMD_EA_I[1:0];
  wire is_load = kind == ccd_pkg::CMD_LOAD;
  wire is_store = kind == ccd_pkg::CMD_STORE;
  wire is_flush = kind == ccd_pkg::CMD_FLUSH;
  wire is_other = kind == ccd_pkg::CMD_OTHER;
  wire is_idbg = kind == ccd_pkg::CMD_IDEBUG;
  wire is_ddbg = kind == ccd_pkg::CMD_DDEBUG;

  // Outstanding operation counters
  logic [1:0] loads, stores, flushes;
  logic other_busy;
  logic second_load_pending;
  ccd_pkg::ccd_fb_t fb_state;
  logic fb_next_dirty, fb_next_load;
  logic fb_dirty;
  logic fb_extra;
  logic fb_target_load;

  wire fb_writing = fb_state == ccd_pkg::FB_WRITE;
  wire fb_busy = fb_state != ccd_pkg::FB_IDLE;
  wire needs_fb = (is_load || is_store) && !CMD_HIT_I;
  wire any_prior = (loads != 2'd0) || (stores != 2'd0) || (flushes != 2'd0) || fb_busy;

  wire stall_fill = fb_writing;
  wire stall_load = (is_load && loads == 2'(`CCD_MAX_LOADS))
    || (USES_LOAD_DATA_I && loads != 2'd0)
    || second_load_pending;
  wire stall_fb = fb_busy && needs_fb && fb_extra;
  wire stall_store = stores == 2'(`CCD_MAX_STORES);
  wire stall_flush = flushes == 2'(`CCD_MAX_FLUSH);
  wire stall_other = other_busy || (is_other && any_prior);
  wire stall_any = stall_fill || stall_load || stall_fb || stall_store
    || stall_flush || stall_other;

  assign CMD_STALL_O = CMD_VALID_I && stall_any;
  assign CMD_ACCEPT_O = CMD_VALID_I && !stall_any;
  wire acc = CMD_ACCEPT_O;
  wire acc_miss = acc && needs_fb;
  wire start_fill = acc_miss && !fb_busy;

  wire load_inc = acc && is_load && !CMD_HIT_I;
  logic [1:0] next_loads, next_stores, next_flushes;
  assign next_loads = loads + 2'(load_inc) - 2'(LOAD_DONE_I && loads != 2'd0);
  assign next_stores = stores + 2'(acc && is_store && !CMD_HIT_I)
    - 2'(STORE_DONE_I && stores != 2'd0);
  assign next_flushes = flushes + 2'(acc && (is_flush || (acc_miss && CMD_DIRTY_VICTIM_I)))
    - 2'(FLUSH_DONE_I && flushes != 2'd0);

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loads <= 2'd0;
      stores <= 2'd0;
      flushes <= 2'd0;
      other_busy <= 1'b0;
      second_load_pending <= 1'b0;
    end
    else
    begin
      loads <= next_loads;
      stores <= next_stores;
      flushes <= next_flushes;
      other_busy <= (acc && is_other) || (other_busy && !OTHER_DONE_I);
      // Second load reads the array one cycle after acceptance
      second_load_pending <= load_inc && loads != 2'd0;
    end
  end

  // Fill buffer sequencing
  logic [1:0] wb_cnt;
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fb_state <= ccd_pkg::FB_IDLE;
      fb_next_dirty <= 1'b0;
      fb_next_load <= 1'b0;
      fb_dirty <= 1'b0;
      fb_extra <= 1'b0;
      fb_target_load <= 1'b0;
      wb_cnt <= 2'd0;
    end
    else
    begin
      unique case (fb_state)
        ccd_pkg::FB_IDLE:
        begin
          fb_extra <= 1'b0;
          if (start_fill)
          begin
            fb_state <= ccd_pkg::FB_FILL;
            fb_dirty <= CMD_DIRTY_VICTIM_I;
            fb_target_load <= is_load;
          end
        end
        ccd_pkg::FB_FILL:
        begin
          if (acc_miss)
          begin
            fb_extra <= 1'b1;
            fb_next_dirty <= CMD_DIRTY_VICTIM_I;
            fb_next_load <= is_load;
          end
          if (FILL_WORD_VALID_I)
          begin
            if (FILL_LAST_I)
            begin
              fb_state <= ccd_pkg::FB_WRITE;
              wb_cnt <= fb_dirty ? 2'(`CCD_FILL_DIRTY - 1) : 2'(`CCD_FILL_CLEAN - 1);
            end
          end
        end
        ccd_pkg::FB_WRITE:
        begin
          if (wb_cnt == 2'd0)
          begin
            fb_state <= fb_extra ? ccd_pkg::FB_FILL : ccd_pkg::FB_IDLE;
            // Queued miss takes over the buffer with its own victim and target
            fb_dirty <= fb_next_dirty;
            fb_target_load <= fb_next_load;
            fb_extra <= 1'b0;
          end
          else
          begin
            wb_cnt <= wb_cnt - 2'd1;
          end
        end
        default:
        begin
          fb_state <= ccd_pkg::FB_IDLE;
        end
      endcase
    end
  end

  // Target word bypass one cycle after arrival
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      LOAD_FWD_VALID_O <= 1'b0;
      LOAD_FWD_DATA_O <= 32'h0000_0000;
    end
    else
    begin
      LOAD_FWD_VALID_O <= FILL_WORD_VALID_I && FILL_TARGET_I && fb_target_load;
      if (FILL_WORD_VALID_I && FILL_TARGET_I)
      begin
        LOAD_FWD_DATA_O <= FILL_WORD_I;
      end
    end
  end

  // Word arrays: side, way, set, word
  logic [AW+1:0] mem_raddr, mem_waddr;
  logic [31:0] mem_rdata;
  assign mem_waddr = {ARR_SIDE_I, ARR_WAY_I, ARR_SET_I, ARR_WORD_I};
  assign mem_raddr = {is_ddbg, way_select, ea_set, ea_word};
  ccd_mem #(
    .WIDTH(32),
    .DEPTH(4 * SETS * 8)
  ) u_mem (
    .clk_i(SYS_CLK_I),
    .we_i(ARR_WE_I),
    .waddr_i(mem_waddr),
    .wdata_i(ARR_WDATA_I),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // Tag readout formats
  wire [31:0] itag_word = {way_select ? ITAG_B_I : ITAG_A_I, 5'h00,
    IVALID_I[way_select], 3'h0, ILRU_B_I};
  wire [31:0] dtag_word = {way_select ? DTAG_B_I : DTAG_A_I, 6'h00,
    DDIRTY_I[way_select], DVALID_I[way_select], 3'h0, DLRU_B_I};

  logic idbg_q, ddbg_q, info_q;
  logic [31:0] itag_q, dtag_q;
  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idbg_q <= 1'b0;
      ddbg_q <= 1'b0;
      info_q <= 1'b0;
      itag_q <= 32'h0000_0000;
      dtag_q <= 32'h0000_0000;
      ALIGN_EXC_O <= 1'b0;
    end
    else
    begin
      idbg_q <= acc && is_idbg;
      ddbg_q <= acc && is_ddbg && !(ea_misalign && !info_select);
      info_q <= info_select;
      itag_q <= itag_word;
      dtag_q <= dtag_word;
      ALIGN_EXC_O <= acc && is_ddbg && !info_select && ea_misalign;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ICACHE_DEBUG_DATA_O <= 32'h0000_0000;
      DDEBUG_VALID_O <= 1'b0;
      DDEBUG_DATA_O <= 32'h0000_0000;
    end
    else
    begin
      if (idbg_q)
      begin
        ICACHE_DEBUG_DATA_O <= info_q ? itag_q : mem_rdata;
      end
      DDEBUG_VALID_O <= ddbg_q;
      if (ddbg_q)
      begin
        DDEBUG_DATA_O <= info_q ? dtag_q : mem_rdata;
      end
    end
  end
endmodule : ccd_top

// [hdl/ccd_defs.svh]
// Offsets, field positions, reset values and timing counts for the cache control block
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH
`define CCD_CFG_UXE 14
`define CCD_CFG_LDV 15
`define CCD_CFG_PFC 20
`define CCD_CFG_PFN 21
`define CCD_CFG_NRS 22
`define CCD_CFG_FWA 23
`define CCD_CFG_INFO 27
`define CCD_CFG_WAY 31
`define CCD_CFG_RESET 32'h0000_0000
`define CCD_CFG_WMASK 32'h0003_0f11
`define CCD_SETS 512
`define CCD_FILL_CLEAN 3
`define CCD_FILL_DIRTY 4
`define CCD_MAX_STORES 3
`define CCD_MAX_FLUSH 2
`define CCD_MAX_LOADS 2
`endif

// [hdl/ccd_pkg.sv]
// Types shared by the cache control block
package ccd_pkg;
  typedef enum logic [2:0] {
    CMD_LOAD,
    CMD_STORE,
    CMD_FLUSH,
    CMD_OTHER,
    CMD_IDEBUG,
    CMD_DDEBUG
  } ccd_cmd_t;
  typedef enum logic [1:0] {
    FB_IDLE,
    FB_FILL,
    FB_WRITE
  } ccd_fb_t;
endpackage : ccd_pkg

// [hdl/ccd_mem.sv]
// Small synchronous memory with registered read data
`timescale 1ns/1ps
module ccd_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4096
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : ccd_mem

// [verif/ccd_top_properties.sv]
// Port checker for the cache control block
`timescale 1ns/1ps
module ccd_top_properties (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // Configuration
  input wire logic CFG_WR_I,
  input wire logic [31:0] CFG_WDATA_I,
  input wire logic [31:0] CFG_RDATA_O,
  input wire logic USER_EXC_EN_O,
  input wire logic LOAD_DEBUG_VISIBLE_O,
  input wire logic PREFETCH_CACHABLE_O,
  input wire logic PREFETCH_NONCACHABLE_O,
  input wire logic NC_REQ_EIGHT_WORDS_O,
  input wire logic FETCH_WITHOUT_ALLOCATE_O,
  // Commands and results
  input wire logic CMD_VALID_I,
  input wire logic [2:0] CMD_KIND_I,
  input wire logic [31:0] CMD_EA_I,
  input wire logic CMD_STALL_O,
  input wire logic CMD_ACCEPT_O,
  input wire logic DDEBUG_VALID_O,
  input wire logic ALIGN_EXC_O,
  input wire logic LOAD_FWD_VALID_O,
  // Fill stream
  input wire logic FILL_WORD_VALID_I,
  input wire logic FILL_TARGET_I,
  input wire logic FILL_LAST_I
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  wire logic take = CMD_VALID_I && !CMD_STALL_O;
  wire logic dread = take && CMD_KIND_I == 3'h5 && !CFG_RDATA_O[4];
  wire logic odd = CMD_EA_I[1:0] != 2'h0;
  sequence s_fill_end;
    FILL_WORD_VALID_I && FILL_LAST_I;
  endsequence
  sequence s_blocked;
    (!CMD_VALID_I || CMD_STALL_O) [*3];
  endsequence
  a_cfg_write: assert property (
    CFG_WR_I |=> CFG_RDATA_O == ($past(CFG_WDATA_I) & 32'h0003_0f11)) else $error("cfg write");
  a_cfg_hold: assert property (!CFG_WR_I |=> $stable(CFG_RDATA_O))
    else $error("cfg changed");
  a_cfg_decode: assert property (
    {USER_EXC_EN_O, LOAD_DEBUG_VISIBLE_O, PREFETCH_CACHABLE_O, PREFETCH_NONCACHABLE_O,
    NC_REQ_EIGHT_WORDS_O, FETCH_WITHOUT_ALLOCATE_O} == {CFG_RDATA_O[17:16], CFG_RDATA_O[11:8]})
    else $error("cfg decode");
  a_align_fault: assert property (dread && odd |=> ALIGN_EXC_O ##1 !DDEBUG_VALID_O)
    else $error("align fault");
  a_dword_ready: assert property (dread && !odd |=> !ALIGN_EXC_O ##1 DDEBUG_VALID_O)
    else $error("data word read");
  a_load_forward: assert property (FILL_WORD_VALID_I && FILL_TARGET_I |=> LOAD_FWD_VALID_O)
    else $error("forward late");
  a_fill_stall: assert property (s_fill_end |=> s_blocked)
    else $error("fill write not stalled");
  a_accept_take: assert property (CMD_ACCEPT_O == take)
    else $error("accept mismatch");
  a_other_block: assert property (
    take && CMD_KIND_I == 3'h3 |=> !CMD_VALID_I || CMD_STALL_O) else $error("other op");
endmodule : ccd_top_properties

// [verif/ccd_bus_model.sv]
// Bus controller model: line fill words and completion pulses
`timescale 1ns/1ps
module ccd_bus_model (
  // Clock
  input wire logic clk_i,
  // Fill stream
  output logic fill_valid_o,
  output logic fill_target_o,
  output logic [31:0] fill_word_o,
  output logic fill_last_o,
  // Done pulses: load, store, flush, other
  output logic [3:0] done_o
);
  logic [31:0] word;
  logic [31:0] idle = 32'h0;
  // Idle data toggles so a stale word is never mistaken for a fill
  assign fill_word_o = fill_valid_o ? word : idle;
  initial
  begin
    {fill_valid_o, fill_target_o, fill_last_o, done_o, word} = '0;
  end
  always @(posedge clk_i) idle <= ~idle;
  task fill(input logic [31:0] base, input int tgt);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      fill_valid_o <= 1'b1;
      word <= base + 32'(i);
      fill_target_o <= i == tgt;
      fill_last_o <= i == 7;
    end
    @(posedge clk_i);
    {fill_valid_o, fill_target_o, fill_last_o} <= 3'h0;
  endtask : fill
  task done(input int k);
    @(posedge clk_i);
    done_o[k] <= 1'b1;
    @(posedge clk_i);
    done_o[k] <= 1'b0;
  endtask : done
endmodule : ccd_bus_model

// [verif/tb_top.sv]
// Self-checking testbench for the cache control block
`timescale 1ns/1ps
module tb_top;
  logic SYS_CLK_I, RESET_N_I, CFG_WR_I, ILRU_B_I, DLRU_B_I, ARR_WE_I, ARR_SIDE_I, ARR_WAY_I;
  logic CMD_VALID_I, CMD_HIT_I, CMD_DIRTY_VICTIM_I, USES_LOAD_DATA_I, CMD_STALL_O, CMD_ACCEPT_O;
  logic USER_EXC_EN_O, LOAD_DEBUG_VISIBLE_O, PREFETCH_CACHABLE_O, PREFETCH_NONCACHABLE_O;
  logic NC_REQ_EIGHT_WORDS_O, FETCH_WITHOUT_ALLOCATE_O, DDEBUG_VALID_O, ALIGN_EXC_O;
  logic LOAD_FWD_VALID_O, FILL_WORD_VALID_I, FILL_TARGET_I, FILL_LAST_I;
  logic LOAD_DONE_I, STORE_DONE_I, FLUSH_DONE_I, OTHER_DONE_I;
  logic [31:0] CFG_WDATA_I, CFG_RDATA_O, ARR_WDATA_I, CMD_EA_I, ICACHE_DEBUG_DATA_O;
  logic [31:0] DDEBUG_DATA_O, LOAD_FWD_DATA_O, FILL_WORD_I, ex, r;
  logic [21:0] ITAG_A_I, ITAG_B_I;
  logic [19:0] DTAG_A_I, DTAG_B_I;
  logic [1:0] IVALID_I, DVALID_I, DDIRTY_I;
  logic [8:0] ARR_SET_I;
  logic [2:0] ARR_WORD_I, CMD_KIND_I;
  logic [63:0] t;
  logic [31:0] mem [int];
  int bad_count, check_count, n, k, w;
  int cyc = 0;
  ccd_top u_ccd_top (.*);
  ccd_bus_model u_bus (.clk_i(SYS_CLK_I), .fill_valid_o(FILL_WORD_VALID_I),
    .fill_target_o(FILL_TARGET_I), .fill_word_o(FILL_WORD_I), .fill_last_o(FILL_LAST_I),
    .done_o({OTHER_DONE_I, FLUSH_DONE_I, STORE_DONE_I, LOAD_DONE_I}));
  initial
  begin
    SYS_CLK_I = 1'b0;
    forever #10 SYS_CLK_I = ~SYS_CLK_I;
  end
  always @(posedge SYS_CLK_I)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      test_done;
    end
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  task cfg(input logic [31:0] v);
    @(posedge SYS_CLK_I);
    CFG_WR_I <= 1'b1;
    CFG_WDATA_I <= v;
    @(posedge SYS_CLK_I);
    CFG_WR_I <= 1'b0;
    #1 chk("cfg", v & 32'h0003_0f11, CFG_RDATA_O);
    chk("decode", {26'h0, v[17:16], v[11:8]}, {26'h0, USER_EXC_EN_O, LOAD_DEBUG_VISIBLE_O,
      PREFETCH_CACHABLE_O, PREFETCH_NONCACHABLE_O, NC_REQ_EIGHT_WORDS_O,
      FETCH_WITHOUT_ALLOCATE_O});
  endtask : cfg
  task cmd(input logic [2:0] kd, input logic h, input logic dv, input logic [31:0] ea,
    input logic st);
    @(posedge SYS_CLK_I);
    {CMD_VALID_I, CMD_KIND_I, CMD_HIT_I, CMD_DIRTY_VICTIM_I, CMD_EA_I} <= {1'b1, kd, h, dv, ea};
    #1 chk("stall", {31'h0, st}, {31'h0, CMD_STALL_O});
    @(posedge SYS_CLK_I);
    CMD_VALID_I <= 1'b0;
  endtask : cmd
  initial
  begin
    void'($urandom(9));
    {RESET_N_I, CFG_WR_I, CFG_WDATA_I, ITAG_A_I, ITAG_B_I, IVALID_I, ILRU_B_I, DTAG_A_I,
      DTAG_B_I, DVALID_I, DDIRTY_I, DLRU_B_I, ARR_WE_I, ARR_SIDE_I, ARR_WAY_I, ARR_SET_I,
      ARR_WORD_I, ARR_WDATA_I, CMD_VALID_I, CMD_KIND_I, CMD_HIT_I, CMD_DIRTY_VICTIM_I,
      CMD_EA_I, USES_LOAD_DATA_I} = '0;
    repeat (4) @(posedge SYS_CLK_I);
    RESET_N_I <= 1'b1;
    repeat (3) @(posedge SYS_CLK_I);
    cfg(32'hffff_ffff);
    for (k = 0; k < 4; k++) cfg($urandom);
    for (k = 0; k < 8; k++)
    begin
      r = $urandom & 32'h0000_3ffc;
      ex = $urandom;
      t = {$urandom, $urandom};
      w = k & 1;
      @(posedge SYS_CLK_I);
      {ARR_WE_I, ARR_SIDE_I, ARR_WAY_I, ARR_SET_I, ARR_WORD_I} <= {1'b1, k[2], k[0], r[13:2]};
      {ARR_WDATA_I, ITAG_A_I, ITAG_B_I, IVALID_I, ILRU_B_I} <= {ex, t[46:0]};
      {DTAG_A_I, DTAG_B_I, DVALID_I, DDIRTY_I, DLRU_B_I} <= {t[63:44], t[41:22], t[3:0], t[47]};
      mem[{k[2], k[0], r[13:2]}] = ex;
      @(posedge SYS_CLK_I);
      ARR_WE_I <= 1'b0;
      cfg({27'h0, k[1], 3'h0, k[0]});
      cmd(k[2] ? 3'h5 : 3'h4, 1'b1, 1'b0, r, 1'b0);
      if (!k[1]) ex = mem[{k[2], k[0], r[13:2]}];
      else if (!k[2]) ex = {w ? ITAG_B_I : ITAG_A_I, 5'h0, IVALID_I[w], 3'h0, ILRU_B_I};
      else ex = {w ? DTAG_B_I : DTAG_A_I, 6'h0, DDIRTY_I[w], DVALID_I[w], 3'h0, DLRU_B_I};
      @(posedge SYS_CLK_I);
      #1 chk("debug", ex, k[2] ? DDEBUG_DATA_O : ICACHE_DEBUG_DATA_O);
      if (k[2]) chk("dvalid", 32'h1, {31'h0, DDEBUG_VALID_O});
    end
    cfg(32'h0);
    cmd(3'h5, 1'b1, 1'b0, 32'h0000_0102, 1'b0);
    #1 chk("align", 32'h1, {31'h0, ALIGN_EXC_O});
    @(posedge SYS_CLK_I);
    #1 chk("no data", 32'h0, {31'h0, DDEBUG_VALID_O});
    for (k = 0; k < 2; k++)
    begin
      cmd(3'h0, 1'b0, k[0], 32'h40, 1'b0);
      fork
        u_bus.fill(32'h5a00 << k, 2);
        begin
          repeat (4) @(posedge SYS_CLK_I);
          #1 chk("fwd", 32'h1, {31'h0, LOAD_FWD_VALID_O});
          chk("fwd data", (32'h5a00 << k) + 32'h2, LOAD_FWD_DATA_O);
        end
      join
      {CMD_VALID_I, CMD_KIND_I, CMD_HIT_I, CMD_DIRTY_VICTIM_I} <= {1'b1, 3'h0, 1'b1, 1'b0};
      n = 0;
      #1;
      while (CMD_STALL_O === 1'b1 && n < 9)
      begin
        n++;
        @(posedge SYS_CLK_I);
        #1;
      end
      chk("fill stall", 32'(3 + k), 32'(n));
      @(posedge SYS_CLK_I);
      CMD_VALID_I <= 1'b0;
      u_bus.done(0);
      if (k == 1) u_bus.done(2);
    end
    cmd(3'h2, 1'b1, 1'b0, 32'h80, 1'b0);
    cmd(3'h2, 1'b1, 1'b0, 32'ha0, 1'b0);
    cmd(3'h2, 1'b1, 1'b0, 32'hc0, 1'b1);
    cmd(3'h3, 1'b1, 1'b0, 32'hc0, 1'b1);
    u_bus.done(2);
    u_bus.done(2);
    cmd(3'h3, 1'b1, 1'b0, 32'hc0, 1'b0);
    cmd(3'h0, 1'b1, 1'b0, 32'h0, 1'b1);
    u_bus.done(3);
    cmd(3'h0, 1'b0, 1'b0, 32'h100, 1'b0);
    cmd(3'h0, 1'b0, 1'b0, 32'h200, 1'b0);
    cmd(3'h1, 1'b0, 1'b0, 32'h300, 1'b1);
    cmd(3'h0, 1'b1, 1'b0, 32'h0, 1'b1);
    USES_LOAD_DATA_I <= 1'b1;
    cmd(3'h1, 1'b1, 1'b0, 32'h4, 1'b1);
    USES_LOAD_DATA_I <= 1'b0;
    u_bus.fill(32'h0, 8);
    u_bus.fill(32'h0, 8);
    u_bus.done(0);
    u_bus.done(0);
    cmd(3'h0, 1'b1, 1'b0, 32'h0, 1'b0);
    cmd(3'h1, 1'b1, 1'b0, 32'h4, 1'b0);
    test_done;
  end
endmodule : tb_top
bind ccd_top ccd_top_properties u_props (.*);
